// File: design/mtrc_pkg.sv
// package of the mac transmit request and collision block
// assumes a 125 MHz device clock and 10 Mb/s line bit rate
package mtrc_pkg;
  // timing, in ns and in bit times
  localparam int CLK_NS    = 8;
  localparam int BIT_NS    = 100;
  localparam int SQE_BITS  = 64;
  localparam int SLOT_BITS = 512;
  // longest wait rounds down, least time rounds up
  localparam int SQE_CYC   = (SQE_BITS * BIT_NS) / CLK_NS;
  localparam int SLOT_CYC  = (SLOT_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;

  // register indexes; byte address is four times the index
  localparam int AW = 10;
  localparam logic [AW-1:0] IDX_TX_CMD   = 10'h144;
  localparam logic [AW-1:0] IDX_TX_LEN   = 10'h146;
  localparam logic [AW-1:0] IDX_LINE_CTL = 10'h112;
  localparam logic [AW-1:0] IDX_PWR_CTL  = 10'h114;
  localparam logic [AW-1:0] IDX_BUS_ST   = 10'h118;
  localparam logic [AW-1:0] IDX_EVT_ST   = 10'h120;
  localparam logic [AW-1:0] IDX_EVT_MASK = 10'h122;
  localparam logic [AW-1:0] IDX_COUNTS   = 10'h124;

  // field positions
  localparam int BUS_ST_RXC = 0;
  localparam int BUS_ST_TXC = 1;
  localparam int BUS_ST_PWR = 2;
  localparam int BUS_ST_RDY = 8;
  localparam int LINE_AUI   = 0;
  localparam int PWR_STBY   = 0;
  localparam int PWR_SUSP   = 1;
  localparam int PWR_WAKE   = 2;
  localparam int CNT_W      = 10;
  localparam int MISS_LSB   = 16;

  // event bit positions, shared by status and mask
  localparam int EV_RX_OK   = 0;
  localparam int EV_TX_COL  = 1;
  localparam int EV_LATE    = 2;
  localparam int EV_SQE     = 3;
  localparam int EV_RDY     = 4;
  localparam int EV_MISS_OV = 5;
  localparam int EV_COL_OV  = 6;
  localparam int EV_W       = 7;

  // reset values
  localparam logic [15:0]     LEN_RST  = 16'h0000;
  localparam logic [EV_W-1:0] MASK_RST = 7'h00;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [31:0]   writedata;
  } mtrc_avs_req_s;

  typedef enum {PWR_ON, PWR_STANDBY, PWR_SUSPEND} mtrc_pwr_e;
  typedef enum {TX_IDLE, TX_CMD_HELD, TX_WAIT_SPACE, TX_READY} mtrc_tx_e;
endpackage

// File: design/mtrc_top.sv
// mac transmit request handshake, collision, sqe and sleep logic
// assumes an avalon-mm master on i_mclk and line pins from outside
// Summary of operation
// - on the collision-pair port, missing collision within 64 bits after transmit flags sqe
// - collision timing uses a slot time of 512 bit times
// - receive activity on twisted pair, or collision-pair activity on the aui port, during own transmission is a transmit collision
// - act-once bits act once per written one; host rewrites to repeat
// - after command and length, space is reserved and ready is shown; frame committed
// - received frame committed from buffering until host finishes transfer
// - every interrupt event lands in event bits or counter overflow bits
// - standby wakes on twisted-pair activity or host command
// - suspend ignores line activity, wakes only on host command
// - host reads bus state bit 8; device sets it when frame may proceed
`timescale 1ns/1ns
module mtrc_top #(
  parameter int SLOT_CYC_P = mtrc_pkg::SLOT_CYC
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  input  wire mtrc_pkg::mtrc_avs_req_s i_avs,
  output logic [31:0]                 o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire logic [15:0]            i_buf_free,
  input  wire logic                   i_tx_active,
  input  wire logic                   i_tx_data_done,
  input  wire logic                   i_rx_buffered,
  input  wire logic                   i_rx_done,
  input  wire logic                   i_rx_missed,
  input  wire logic                   i_rx_pin,
  input  wire logic                   i_ci_pin,
  output logic                        o_tx_commit,
  output logic [15:0]                 o_tx_len,
  output logic                        o_pwr_down,
  output logic                        o_irq
);
  import mtrc_pkg::*;

  // bus decode
  wire acc_w   = i_avs.write & ~o_avs_waitrequest;
  wire acc_r   = i_avs.read & ~o_avs_waitrequest;
  wire wr_cmd  = acc_w & (i_avs.address == IDX_TX_CMD);
  wire wr_len  = acc_w & (i_avs.address == IDX_TX_LEN);
  wire wr_line = acc_w & (i_avs.address == IDX_LINE_CTL);
  wire wr_pwr  = acc_w & (i_avs.address == IDX_PWR_CTL);
  wire wr_evt  = acc_w & (i_avs.address == IDX_EVT_ST);
  wire wr_mask = acc_w & (i_avs.address == IDX_EVT_MASK);
  // act-once strobes, one cycle per written one
  wire go_stby = wr_pwr & i_avs.writedata[PWR_STBY];
  wire go_susp = wr_pwr & i_avs.writedata[PWR_SUSP];
  wire go_wake = wr_pwr & i_avs.writedata[PWR_WAKE];

  logic            aui_q;
  logic [EV_W-1:0] evt_q;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] evt_set;
  logic            rx_c_q;
  logic [CNT_W-1:0] col_cnt_q;
  logic [CNT_W-1:0] miss_cnt_q;
  mtrc_tx_e        tx_q;
  mtrc_pwr_e       pwr_q;

  // pin synchronisers, three stages each
  logic [2:0] rx_s_q;
  logic [2:0] ci_s_q;
  logic       rx_f_q;
  logic       ci_f_q;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rx_s_q <= 3'h0;
      ci_s_q <= 3'h0;
      rx_f_q <= 1'b0;
      ci_f_q <= 1'b0;
    end else begin
      rx_s_q <= {rx_s_q[1:0], i_rx_pin};
      ci_s_q <= {ci_s_q[1:0], i_ci_pin};
      if (rx_s_q[1] == rx_s_q[2]) rx_f_q <= rx_s_q[2];
      if (ci_s_q[1] == ci_s_q[2]) ci_f_q <= ci_s_q[2];
    end
  end

  // collision source by port
  wire line_act = aui_q ? ci_f_q : rx_f_q;
  logic tx_d_q;
  logic col_seen_q;
  wire col_now = i_tx_active & line_act & ~col_seen_q;
  wire tx_end  = tx_d_q & ~i_tx_active;

  // slot timer from transmit start; collision after it is late
  logic [15:0] slot_q;
  wire slot_over = (slot_q >= 16'(SLOT_CYC_P));
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      tx_d_q     <= 1'b0;
      col_seen_q <= 1'b0;
      slot_q     <= 16'h0000;
    end else begin
      tx_d_q <= i_tx_active;
      if (!i_tx_active) begin
        col_seen_q <= 1'b0;
        slot_q     <= 16'h0000;
      end else begin
        if (col_now) col_seen_q <= 1'b1;
        if (!slot_over) slot_q <= slot_q + 16'h0001;
      end
    end
  end

  // an early collision must not leave the late bit behind
  a_early_no_late: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    col_now && !slot_over && !evt_q[EV_LATE] |=> !evt_q[EV_LATE])
    else $error("late collision flagged inside slot time");

  // sqe window after transmit end, collision-pair port only
  logic [9:0] sqe_q;
  logic       sqe_run_q;
  wire sqe_fail = sqe_run_q & ~ci_f_q & (sqe_q == 10'(SQE_CYC - 1));
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      sqe_run_q <= 1'b0;
      sqe_q     <= 10'h000;
    end else if (tx_end && aui_q) begin
      sqe_run_q <= 1'b1;
      sqe_q     <= 10'h000;
    end else if (sqe_run_q) begin
      if (ci_f_q || sqe_fail) sqe_run_q <= 1'b0;
      sqe_q <= sqe_q + 10'h001;
    end
  end

  // twisted-pair transmissions never open a heartbeat window
  a_sqe_twisted: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    tx_end && !aui_q && !sqe_run_q |=> !sqe_run_q)
    else $error("heartbeat window opened on twisted pair");

  // transmit request sequence
  logic [15:0] len_q;
  wire space_ok = (tx_q == TX_WAIT_SPACE) & ~wr_cmd & (len_q <= i_buf_free);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      tx_q        <= TX_IDLE;
      len_q       <= LEN_RST;
      o_tx_commit <= 1'b0;
      o_tx_len    <= LEN_RST;
    end else begin
      o_tx_commit <= space_ok;
      if (space_ok) o_tx_len <= len_q;
      if (wr_len) len_q <= i_avs.writedata[15:0];
      unique case (tx_q)
        TX_IDLE: begin
          if (wr_cmd) tx_q <= TX_CMD_HELD;
        end
        TX_CMD_HELD: begin
          if (wr_len) tx_q <= TX_WAIT_SPACE;
        end
        TX_WAIT_SPACE: begin
          if (wr_cmd) tx_q <= TX_CMD_HELD;
          else if (space_ok) tx_q <= TX_READY;
        end
        TX_READY: begin
          if (i_tx_data_done) tx_q <= TX_IDLE;
          else if (wr_cmd) tx_q <= TX_CMD_HELD;
        end
      endcase
    end
  end
  wire rdy = (tx_q == TX_READY);

  // commit is a single pulse; ready holds until data is moved or a new command is written
  a_commit_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_tx_commit |=> !o_tx_commit)
    else $error("commit pulse longer than one cycle");
  a_ready_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    rdy && !i_tx_data_done && !wr_cmd |=> rdy)
    else $error("ready dropped before data moved");
  a_ready_drop: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    rdy && i_tx_data_done |=> tx_q == TX_IDLE)
    else $error("ready kept after data moved");

  // receive commit and counters
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rx_c_q     <= 1'b0;
      col_cnt_q  <= '0;
      miss_cnt_q <= '0;
    end else begin
      if (i_rx_buffered) rx_c_q <= 1'b1;
      else if (i_rx_done) rx_c_q <= 1'b0;
      if (col_now) col_cnt_q <= col_cnt_q + 10'h001;
      if (i_rx_missed) miss_cnt_q <= miss_cnt_q + 10'h001;
    end
  end

  // receive commit ends on transfer; missed counter wrap raises its event
  a_rx_release: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    rx_c_q && i_rx_done && !i_rx_buffered |=> !rx_c_q)
    else $error("receive commit not released");
  a_miss_wrap: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_rx_missed && (&miss_cnt_q) |=> evt_q[EV_MISS_OV] && miss_cnt_q == '0)
    else $error("missed counter wrap not reported");

  // event sources
  always_comb begin
    evt_set             = '0;
    evt_set[EV_RX_OK]   = i_rx_buffered;
    evt_set[EV_TX_COL]  = col_now;
    evt_set[EV_LATE]    = col_now & slot_over;
    evt_set[EV_SQE]     = sqe_fail;
    evt_set[EV_RDY]     = space_ok;
    evt_set[EV_MISS_OV] = i_rx_missed & (&miss_cnt_q);
    evt_set[EV_COL_OV]  = col_now & (&col_cnt_q);
  end

  // sticky status, write one clears, set wins; mask; irq
  wire [EV_W-1:0] evt_clr = wr_evt ? i_avs.writedata[EV_W-1:0] : '0;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      evt_q  <= '0;
      mask_q <= MASK_RST;
      aui_q  <= 1'b0;
      o_irq  <= 1'b0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      if (wr_mask) mask_q <= i_avs.writedata[EV_W-1:0];
      if (wr_line) aui_q <= i_avs.writedata[LINE_AUI];
      o_irq <= |(((evt_q & ~evt_clr) | evt_set) & mask_q);
    end
  end

  // irq level follows unmasked sticky bits
  a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !wr_evt && ((evt_q & mask_q) != '0) |=> o_irq)
    else $error("irq low with unmasked event");
  a_irq_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ((evt_q & mask_q) == '0) && (evt_set == '0) |=> !o_irq)
    else $error("irq high with no unmasked event");

  // power modes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      pwr_q      <= PWR_ON;
      o_pwr_down <= 1'b0;
    end else begin
      unique case (pwr_q)
        PWR_ON: begin
          if (go_susp) pwr_q <= PWR_SUSPEND;
          else if (go_stby) pwr_q <= PWR_STANDBY;
        end
        PWR_STANDBY: begin
          if (go_wake || rx_f_q) pwr_q <= PWR_ON;
        end
        PWR_SUSPEND: begin
          if (go_wake) pwr_q <= PWR_ON;
        end
      endcase
      o_pwr_down <= (pwr_q != PWR_ON);
    end
  end

  // sleep flag, host wake and act-once standby entry
  a_pwr_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pwr_q != PWR_ON |=> o_pwr_down)
    else $error("power-down flag missing in sleep");
  a_wake_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pwr_q != PWR_ON && go_wake |=> pwr_q == PWR_ON)
    else $error("host wake ignored");
  a_stby_enter: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pwr_q == PWR_ON && go_stby && !go_susp |=> pwr_q == PWR_STANDBY)
    else $error("standby write did not act");

  // read mux; unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs.address)
      IDX_LINE_CTL: rd_mux[LINE_AUI] = aui_q;
      IDX_BUS_ST: begin
        rd_mux[BUS_ST_RXC] = rx_c_q;
        rd_mux[BUS_ST_TXC] = rdy;
        rd_mux[BUS_ST_PWR +: 2] = (pwr_q == PWR_ON) ? 2'h0 : (pwr_q == PWR_STANDBY) ? 2'h1 : 2'h2;
        rd_mux[BUS_ST_RDY] = rdy;
      end
      IDX_EVT_ST:   rd_mux[EV_W-1:0] = evt_q;
      IDX_EVT_MASK: rd_mux[EV_W-1:0] = mask_q;
      IDX_COUNTS: begin
        rd_mux[CNT_W-1:0] = col_cnt_q;
        rd_mux[MISS_LSB +: CNT_W] = miss_cnt_q;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // avalon slave: waitrequest drops for one cycle per request
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= ~((i_avs.read | i_avs.write) & o_avs_waitrequest);
      if (i_avs.read && o_avs_waitrequest) o_avs_readdata <= rd_mux;
    end
  end

  // exactly one wait cycle per request
  a_wait_one: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_avs.read || i_avs.write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("wait cycle count wrong");

  // checks
  sequence s_tx_fell;
    tx_d_q && !i_tx_active && aui_q;
  endsequence
  sequence s_ci_quiet;
    !ci_f_q [*8];
  endsequence

  a_sqe_flag_time: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    sqe_fail |=> evt_q[EV_SQE] && !sqe_run_q)
    else $error("sqe not flagged at window end");
  a_sqe_arm_aui: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_tx_fell ##1 s_ci_quiet |-> sqe_run_q)
    else $error("sqe window not armed");
  a_late_after_slot: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    col_now && slot_over |=> evt_q[EV_LATE])
    else $error("late collision not reported");
  a_col_detect: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_tx_active && line_act && !col_seen_q |=> evt_q[EV_TX_COL])
    else $error("collision not reported");
  a_cmd_once: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_cmd |=> tx_q == TX_CMD_HELD)
    else $error("command write did not start request");
  a_ready_commit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    space_ok |=> rdy && o_tx_commit && o_tx_len == $past(len_q))
    else $error("commit not shown");
  a_rx_commit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_rx_buffered |=> rx_c_q && evt_q[EV_RX_OK])
    else $error("received frame not committed");
  a_evt_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    evt_q[EV_SQE] && !(wr_evt && i_avs.writedata[EV_SQE]) |=> evt_q[EV_SQE])
    else $error("event bit lost");
  a_standby_wake: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pwr_q == PWR_STANDBY && rx_f_q |=> pwr_q == PWR_ON ##1 !o_pwr_down)
    else $error("standby missed line wake");
  a_suspend_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pwr_q == PWR_SUSPEND && !go_wake |=> pwr_q == PWR_SUSPEND)
    else $error("suspend left without command");
  a_len_order: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    tx_q == TX_IDLE && wr_len |=> tx_q != TX_WAIT_SPACE)
    else $error("length without command accepted");
  a_ready_read: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    acc_r && i_avs.address == IDX_BUS_ST |-> o_avs_readdata[BUS_ST_RDY] == $past(rdy))
    else $error("ready bit not read back");
endmodule

// File: verif/mtrc_medium.sv
// medium model: own transmission, line activity, collision pair
// assumes the bench calls its tasks; lines idle low outside activity
`timescale 1ns/1ns
module mtrc_medium (
  input  wire logic i_mclk,
  output logic      o_tx_active,
  output logic      o_rx_pin,
  output logic      o_ci_pin
);
  // quiet line at time zero
  initial begin
    o_tx_active = 1'b0;
    o_rx_pin    = 1'b0;
    o_ci_pin    = 1'b0;
  end
  // one transmission; col_at 0 keeps the line clean, hb sends a heartbeat
  task automatic xmit(input bit aui, input int len, input int col_at, input bit hb);
    for (int n = 0; n < len; n++) begin
      @(posedge i_mclk);
      o_tx_active <= 1'b1;
      if (col_at != 0 && n == col_at) begin
        if (aui) o_ci_pin <= 1'b1;
        else o_rx_pin <= 1'b1;
      end
      if (col_at != 0 && n == col_at + 10) begin
        o_ci_pin <= 1'b0;
        o_rx_pin <= 1'b0;
      end
    end
    @(posedge i_mclk);
    o_tx_active <= 1'b0;
    repeat (20) @(posedge i_mclk);
    // heartbeat on the collision pair within 64 bit times
    if (hb) begin
      o_ci_pin <= 1'b1;
      repeat (10) @(posedge i_mclk);
      o_ci_pin <= 1'b0;
    end
  endtask
  // receive activity burst on the twisted pair
  task automatic line_burst();
    @(posedge i_mclk);
    o_rx_pin <= 1'b1;
    repeat (10) @(posedge i_mclk);
    o_rx_pin <= 1'b0;
  endtask
endmodule

// File: verif/mtrc_top_tb_top.sv
// bench for the transmit request, collision, sqe and sleep block
// assumes mtrc_pkg and mtrc_medium are compiled first
`timescale 1ns/1ns
module mtrc_top_tb_top;
  import mtrc_pkg::*;
  logic          i_mclk;
  logic          i_rst_b;
  mtrc_avs_req_s avs;
  logic [31:0]   rdata;
  logic [31:0]   q;
  logic          wreq, commit, pwr_down, irq, tx_act, rx_pin, ci_pin;
  logic [15:0]   buf_free;
  logic [15:0]   tx_len;
  logic          tx_done, rx_buf, rx_done, rx_miss;
  int            err_total = 0;
  int            cmp_count = 0;
  int            cyc = 0;
  int            commits = 0;

  mtrc_top #(.SLOT_CYC_P(64)) mtrc_top_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_buf_free(buf_free), .i_tx_active(tx_act),
    .i_tx_data_done(tx_done), .i_rx_buffered(rx_buf), .i_rx_done(rx_done), .i_rx_missed(rx_miss),
    .i_rx_pin(rx_pin), .i_ci_pin(ci_pin), .o_tx_commit(commit), .o_tx_len(tx_len),
    .o_pwr_down(pwr_down), .o_irq(irq));
  mtrc_medium mtrc_medium_i (.i_mclk(i_mclk), .o_tx_active(tx_act), .o_rx_pin(rx_pin), .o_ci_pin(ci_pin));

  // clock, 8 ns period
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // commit pulse count and hang guard
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (commit === 1'b1) commits <= commits + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // one avalon request, held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    avs <= '{read: !wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge i_mclk);
    end while (wreq !== 1'b0);
    q = rdata;
    avs <= '0;
  endtask
  // pulse one input for a cycle
  task automatic pulse(input int k);
    @(posedge i_mclk);
    case (k)
      0: tx_done <= 1'b1;
      1: rx_buf <= 1'b1;
      2: rx_done <= 1'b1;
      default: rx_miss <= 1'b1;
    endcase
    @(posedge i_mclk);
    {tx_done, rx_buf, rx_done, rx_miss} <= 4'h0;
    tick(2);
  endtask

  task automatic t_reset();
    chk(wreq, 1);
    chk(irq, 0);
    chk(tx_len, 0);
    chk(pwr_down, 0);
    bus(0, 10'h3FF, 0);
    chk(q, 0);
  endtask
  task automatic t_tx();
    bus(1, IDX_TX_LEN, 32'h20);
    tick(3);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RDY], 0);
    bus(1, IDX_TX_CMD, 0);
    bus(1, IDX_TX_LEN, 32'h20);
    tick(3);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RDY], 1);
    chk(commits, 1);
    chk(tx_len, 16'h0020);
    bus(0, IDX_EVT_ST, 0);
    chk(q[EV_RDY], 1);
    pulse(0);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RDY], 0);
    bus(1, IDX_TX_CMD, 0);
    bus(1, IDX_TX_LEN, 32'h80);
    tick(3);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RDY], 0);
    buf_free <= 16'h0100;
    tick(3);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RDY], 1);
    chk(tx_len, 16'h0080);
    chk(commits, 2);
    pulse(0);
    bus(1, IDX_EVT_ST, 32'h7F);
  endtask
  task automatic t_col();
    bus(1, IDX_EVT_MASK, 32'h02);
    mtrc_medium_i.xmit(0, 40, 10, 0);
    tick(5);
    bus(0, IDX_EVT_ST, 0);
    chk(q, 32'h02);
    chk(irq, 1);
    bus(1, IDX_EVT_ST, 32'h02);
    tick(2);
    chk(irq, 0);
    mtrc_medium_i.xmit(0, 100, 80, 0);
    tick(5);
    bus(0, IDX_EVT_ST, 0);
    chk(q, 32'h06);
    bus(1, IDX_EVT_ST, 32'h7F);
  endtask
  task automatic t_sqe();
    bus(1, IDX_LINE_CTL, 32'h1);
    mtrc_medium_i.xmit(1, 40, 0, 0);
    tick(850);
    bus(0, IDX_EVT_ST, 0);
    chk(q, 32'h08);
    bus(1, IDX_EVT_ST, 32'h7F);
    mtrc_medium_i.xmit(1, 40, 0, 1);
    tick(850);
    bus(0, IDX_EVT_ST, 0);
    chk(q, 0);
    bus(1, IDX_LINE_CTL, 0);
  endtask
  task automatic t_rx();
    pulse(1);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RXC], 1);
    pulse(2);
    bus(0, IDX_BUS_ST, 0);
    chk(q[BUS_ST_RXC], 0);
    pulse(3);
    bus(0, IDX_COUNTS, 0);
    chk(q[25:16], 1);
    bus(0, IDX_EVT_ST, 0);
    chk(q, 32'h01);
    repeat (1023) pulse(3);
    bus(0, IDX_COUNTS, 0);
    chk(q[25:16], 0);
    bus(0, IDX_EVT_ST, 0);
    chk(q, 32'h21);
  endtask
  task automatic t_pwr();
    bus(1, IDX_PWR_CTL, 32'h1);
    tick(2);
    chk(pwr_down, 1);
    bus(0, IDX_BUS_ST, 0);
    chk(q[3:2], 1);
    mtrc_medium_i.line_burst();
    tick(4);
    chk(pwr_down, 0);
    tick(5);
    chk(pwr_down, 0);
    bus(1, IDX_PWR_CTL, 32'h2);
    tick(2);
    mtrc_medium_i.line_burst();
    tick(4);
    chk(pwr_down, 1);
    bus(1, IDX_PWR_CTL, 32'h4);
    tick(2);
    chk(pwr_down, 0);
  endtask

  // reset, then every scenario in turn
  initial begin
    i_rst_b = 1'b0;
    avs = '0;
    buf_free = 16'h0040;
    {tx_done, rx_buf, rx_done, rx_miss} = 4'h0;
    tick(10);
    i_rst_b <= 1'b1;
    t_reset();
    t_tx();
    t_col();
    t_sqe();
    t_rx();
    t_pwr();
    end_sim();
  end
endmodule
